// ### logic/fcs_pkg.sv
/*
 fault code and shipping state package: fault word layout, log depth,
 substitute readout values and controller states.
 assumes a single system clock domain.
*/
`default_nettype none
package fcs_pkg;
    localparam int FCS_WORD_W      = 16;
    localparam int FCS_LOG_DEPTH   = 50;
    localparam int FCS_DATE_W      = 24;
    localparam int FCS_TIME_W      = 24;
    localparam int FCS_ENERGY_W    = 32;
    localparam int FCS_CNT_W       = 16;
    // fault word bit positions
    localparam int BIT_SUPPLY_LOST = 0;
    localparam int BIT_LOW_BATT    = 1;
    localparam int BIT_EXT_ALARM   = 2;
    localparam int BIT_INLET_HIGH  = 3;
    localparam int BIT_OUTLET_HIGH = 4;
    localparam int BIT_INLET_LOW   = 5;
    localparam int BIT_OUTLET_LOW  = 6;
    localparam int BIT_BAD_DIFF    = 7;
    localparam int BIT_FLOW_AIR    = 8;
    localparam int BIT_FLOW_REV    = 9;
    localparam int BIT_OVERFLOW    = 11;
    localparam int BIT_LEAK_A      = 12;
    localparam int BIT_LEAK_B      = 13;
    localparam int BIT_ALARM_A     = 14;
    localparam int BIT_ALARM_B     = 15;
    // substitute serial values, hundredths of degC, litres/h, 0.1 kW
    localparam logic [15:0] TEMP_SUB_LOW  = 16'h0000;
    localparam logic [15:0] TEMP_SUB_HIGH = 16'h4844; // 185,00 degC
    localparam logic [23:0] FLOW_SUB      = 24'h000000;
    localparam logic [23:0] POWER_SUB     = 24'h000000;
    localparam logic [15:0] FAULT_CLEAR   = 16'h0000;

    typedef enum logic [2:0] {
        FCS_SHIP    = 3'b001,
        FCS_RUN     = 3'b010,
        FCS_VERIFY  = 3'b100
    } fcs_state_t;

    typedef enum logic [2:0] {
        FCS_VIEW_OTHER = 3'b001,
        FCS_VIEW_CODE  = 3'b010,
        FCS_VIEW_COUNT = 3'b100
    } fcs_view_t;

    typedef struct packed {
        logic [FCS_DATE_W-1:0]   date;
        logic [FCS_TIME_W-1:0]   time_of_day;
        logic [FCS_WORD_W-1:0]   code;
        logic [FCS_ENERGY_W-1:0] heatEnergy;
        logic [FCS_ENERGY_W-1:0] coolEnergy;
    } fcs_log_t;

    typedef struct packed {
        logic [15:0] inletTemp;
        logic [15:0] outletTemp;
        logic [23:0] flow;
        logic [23:0] power;
    } fcs_meas_t;
endpackage
`default_nettype wire

// ### logic/fault_code_and_shipping_state.sv
/*
 fault code and shipping state controller: builds the fault word, drives
 the flashing indicator, counts and logs code changes, steps the log view
 from the keys, substitutes safe readout values and runs shipping state.
 assumes monitor, key and seal inputs are pins (synchronised here);
 date, time, energy and measurement words come from same-clock logic.
*/
// Operation
// - flash fault indicator while fault code is nonzero.
// - stop flashing while display shows current fault code.
// - count each fault code change; secondary key shows counter.
// - counter starts at zero and does not count in shipping state.
// - further secondary presses show latest date, then code, alternating.
// - log keeps 50 latest changes, all viewable.
// - faulty sensor shows dashes and stops dependent energy accumulation.
// - faulty temperature reads 0,00 or 185,00 serially; dashes displayed.
// - bad difference alone is not a temperature sensor fault.
// - temperature fault dashes difference and power; power reads 0,0 kW.
// - flow fault reads 0 l/h and 0,0 kW; flow and power dashed.
// - flow above max limit is no flow fault; measuring continues.
// - serial fault word has one fixed bit per cause.
// - shipping state shows codes but logs nothing; first flow activates.
// - shipping state lasts until first integration, finish configuration or verification entry; only total reset returns.
// - shipping uses power saving sequence, then configured profile.
// - menu open in shipping; finish configuration blocks it, ends shipping.
// - after commissioning, separating top and base reopens the menu.
// - radio off on delivery, enabled by first integration.
// - menu or both-keys dial enables radio without leaving shipping.
// - verification menu disables radio; nothing re-enables it there.
// - each logged change holds date, time, code, heat and cooling energy.
// - no counting or logging while top and base are separated.
`timescale 1ns/1ps
`default_nettype none
module fault_code_and_shipping_state
    import fcs_pkg::*;
#(
    parameter int LOG_DEPTH = FCS_LOG_DEPTH
) (
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    input  wire logic [FCS_WORD_W-1:0]   monitorFaults,
    input  wire logic                    primaryKey,
    input  wire logic                    secondaryKey,
    input  wire logic                    bothKeysHeld,
    input  wire logic                    housingOpen,
    input  wire logic                    integrationPulse,
    input  wire logic                    finishConfiguration,
    input  wire logic                    menuRadioEnable,
    input  wire logic                    verifyEnter,
    input  wire logic                    verifyExit,
    input  wire logic                    configMenuReq,
    input  wire logic [1:0]              profileCode,
    input  wire logic [FCS_DATE_W-1:0]   dateNow,
    input  wire logic [FCS_TIME_W-1:0]   timeNow,
    input  wire logic [FCS_ENERGY_W-1:0] heatEnergy,
    input  wire logic [FCS_ENERGY_W-1:0] coolEnergy,
    input  wire fcs_meas_t               measRaw,
    output logic [FCS_WORD_W-1:0]        fault_status_word,
    output logic                         faultFlash,
    output fcs_view_t                    viewMode,
    output logic [FCS_WORD_W-1:0]        viewValue,
    output logic [FCS_DATE_W-1:0]        viewDate,
    output logic                         viewIsDate,
    output logic [FCS_CNT_W-1:0]         eventCount,
    output fcs_meas_t                    measSerial,
    output logic                         dashInlet,
    output logic                         dashOutlet,
    output logic                         dashDiff,
    output logic                         dashFlow,
    output logic                         dashPower,
    output logic                         holdHeatEnergy,
    output logic                         holdCoolEnergy,
    output logic                         shipping,
    output logic                         powerSaveSeq,
    output logic [1:0]                   measProfile,
    output logic                         menuAccess,
    output logic                         radioEnable
);
    localparam int IDX_W = $clog2(LOG_DEPTH);

    // pin inputs pass two flip-flops first
    localparam int SYN_W = FCS_WORD_W + 4;
    logic [SYN_W-1:0] syncA;
    logic [SYN_W-1:0] syncB;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= {monitorFaults, primaryKey, secondaryKey,
                      bothKeysHeld, housingOpen};
            syncB <= syncA;
        end
    end
    wire [FCS_WORD_W-1:0] faultIn = syncB[SYN_W-1:4];
    wire primS = syncB[3];
    wire secS  = syncB[2];
    wire bothS = syncB[1];
    wire openS = syncB[0];

    logic primD;
    logic secD;
    logic bothD;
    wire primPress = primS & ~primD;
    wire secPress  = secS & ~secD;
    wire dialPress = bothS & ~bothD;

    // bit 10 has no cause and always reads zero
    wire [FCS_WORD_W-1:0] next_fault = faultIn & ~16'h0400;
    logic [FCS_WORD_W-1:0] prevFault;
    logic                  started;
    wire codeChange = started && (next_fault != prevFault);

    fcs_state_t state;
    wire inShip   = (state == FCS_SHIP);
    wire inVerify = (state == FCS_VERIFY);
    wire logEvent = codeChange && !inShip && !openS;

    // change log ring
    fcs_log_t           logMem [LOG_DEPTH];
    logic [IDX_W-1:0]   wrPtr;
    logic [IDX_W:0]     logCount;
    logic [IDX_W-1:0]   viewIdx;
    logic [IDX_W:0]     viewStep;
    logic               viewPhase;
    logic               dateSel;

    function automatic logic [IDX_W-1:0] ringBack(
        input logic [IDX_W-1:0] ptr,
        input logic [IDX_W:0]   back
    );
        logic [IDX_W+1:0] sum;
        sum = {2'b00, ptr} + LOG_DEPTH[IDX_W+1:0] - {1'b0, back} - 1'b1;
        if (sum >= LOG_DEPTH[IDX_W+1:0])
            sum = sum - LOG_DEPTH[IDX_W+1:0];
        return sum[IDX_W-1:0];
    endfunction

    wire [IDX_W-1:0] wrNext = (wrPtr == IDX_W'(LOG_DEPTH - 1)) ?
                              '0 : wrPtr + 1'b1;
    wire fcs_log_t newEntry = '{dateNow, timeNow, next_fault,
                                heatEnergy, coolEnergy};

    always_ff @(posedge sys_clk) begin
        if (logEvent)
            logMem[wrPtr] <= newEntry;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            primD      <= 1'b0;
            secD       <= 1'b0;
            bothD      <= 1'b0;
            prevFault  <= FAULT_CLEAR;
            started    <= 1'b0;
            eventCount <= '0;
            wrPtr      <= '0;
            logCount   <= '0;
        end else begin
            primD     <= primS;
            secD      <= secS;
            bothD     <= bothS;
            prevFault <= next_fault;
            started   <= 1'b1;
            if (logEvent) begin
                eventCount <= eventCount + 1'b1;
                wrPtr      <= wrNext;
                if (logCount != (IDX_W+1)'(LOG_DEPTH))
                    logCount <= logCount + 1'b1;
            end
        end
    end

    // display view stepping: primary selects code, secondary walks
    // counter first, then date and code of each entry, newest first;
    // steering from registered state, not from the delayed outputs
    wire stepMore = (viewStep + 1'b1) < logCount;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            viewMode  <= FCS_VIEW_OTHER;
            viewStep  <= '0;
            viewPhase <= 1'b0;
            dateSel   <= 1'b0;
        end else if (primPress) begin
            viewMode  <= (viewMode == FCS_VIEW_OTHER) ?
                         FCS_VIEW_CODE : FCS_VIEW_OTHER;
            viewStep  <= '0;
            viewPhase <= 1'b0;
            dateSel   <= 1'b0;
        end else if (secPress) begin
            case (viewMode)
                FCS_VIEW_CODE: begin
                    viewMode <= FCS_VIEW_COUNT;
                end
                FCS_VIEW_COUNT: begin
                    if (logCount != '0) begin
                        viewPhase <= 1'b1;
                        dateSel   <= ~dateSel | ~viewPhase;
                    end
                    if (viewPhase && !dateSel)
                        viewStep <= stepMore ? viewStep + 1'b1 : '0;
                end
                default: begin
                    viewMode <= viewMode;
                end
            endcase
        end
    end
    assign viewIdx = ringBack(wrPtr, viewStep);
    wire fcs_log_t shownEntry = logMem[viewIdx];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            viewValue  <= '0;
            viewDate   <= '0;
            viewIsDate <= 1'b0;
        end else begin
            viewIsDate <= viewPhase && dateSel;
            viewDate   <= shownEntry.date;
            if (viewMode == FCS_VIEW_CODE)
                viewValue <= next_fault;
            else if (viewMode == FCS_VIEW_COUNT && !viewPhase)
                viewValue <= eventCount;
            else
                viewValue <= shownEntry.code;
        end
    end

    // sensor fault substitution; bad difference bit is left out
    wire inHi  = next_fault[BIT_INLET_HIGH];
    wire inLo  = next_fault[BIT_INLET_LOW];
    wire outHi = next_fault[BIT_OUTLET_HIGH];
    wire outLo = next_fault[BIT_OUTLET_LOW];
    wire tempFault = inHi | inLo | outHi | outLo;
    // overflow bit does not stop measuring
    wire flowFault = next_fault[BIT_FLOW_AIR] |
                     next_fault[BIT_FLOW_REV];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            measSerial        <= '0;
            fault_status_word <= FAULT_CLEAR;
            faultFlash        <= 1'b0;
            dashInlet         <= 1'b0;
            dashOutlet        <= 1'b0;
            dashDiff          <= 1'b0;
            dashFlow          <= 1'b0;
            dashPower         <= 1'b0;
            holdHeatEnergy    <= 1'b0;
            holdCoolEnergy    <= 1'b0;
        end else begin
            fault_status_word <= next_fault;
            faultFlash <= (next_fault != FAULT_CLEAR) &&
                          (viewMode != FCS_VIEW_CODE);
            measSerial.inletTemp  <= inLo ? TEMP_SUB_LOW :
                                     inHi ? TEMP_SUB_HIGH :
                                     measRaw.inletTemp;
            measSerial.outletTemp <= outLo ? TEMP_SUB_LOW :
                                     outHi ? TEMP_SUB_HIGH :
                                     measRaw.outletTemp;
            measSerial.flow  <= flowFault ? FLOW_SUB : measRaw.flow;
            measSerial.power <= (tempFault | flowFault) ?
                                POWER_SUB : measRaw.power;
            dashInlet      <= inHi | inLo;
            dashOutlet     <= outHi | outLo;
            dashDiff       <= tempFault;
            dashFlow       <= flowFault;
            dashPower      <= tempFault | flowFault;
            holdHeatEnergy <= tempFault | flowFault;
            holdCoolEnergy <= tempFault | flowFault;
        end
    end

    // shipping state and radio
    logic menuBlocked;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state       <= FCS_SHIP;
            menuBlocked <= 1'b0;
            radioEnable <= 1'b0;
        end else begin
            case (state)
                FCS_SHIP: begin
                    if (verifyEnter)
                        state <= FCS_VERIFY;
                    else if (integrationPulse || finishConfiguration)
                        state <= FCS_RUN;
                end
                FCS_RUN: begin
                    if (verifyEnter)
                        state <= FCS_VERIFY;
                end
                FCS_VERIFY: begin
                    // verification always returns to the commissioned state
                    if (verifyExit)
                        state <= FCS_RUN;
                end
                default: state <= FCS_SHIP;
            endcase
            if (finishConfiguration)
                menuBlocked <= 1'b1;
            else if (openS && !inShip)
                menuBlocked <= 1'b0;
            if (verifyEnter || inVerify)
                radioEnable <= 1'b0;
            else if (integrationPulse || menuRadioEnable || dialPress)
                radioEnable <= 1'b1;
        end
    end
    assign shipping     = inShip;
    assign powerSaveSeq = inShip;
    assign measProfile  = inShip ? 2'h0 : profileCode;
    assign menuAccess   = !menuBlocked && configMenuReq;

    chk_flash_on_fault: assert property (@(posedge sys_clk)
        disable iff (!reset_n) (next_fault != FAULT_CLEAR &&
        viewMode != FCS_VIEW_CODE) |=> faultFlash)
        else $error("fault indicator not flashing");
    chk_no_count_ship: assert property (@(posedge sys_clk)
        disable iff (!reset_n) inShip |=> $stable(eventCount))
        else $error("event counter moved in shipping");
    chk_count_step: assert property (@(posedge sys_clk)
        disable iff (!reset_n) logEvent |=>
        eventCount == $past(eventCount) + 1'b1)
        else $error("event counter did not step");
    chk_leave_ship: assert property (@(posedge sys_clk)
        disable iff (!reset_n) !inShip |=> !inShip)
        else $error("returned to shipping state");
    chk_radio_verify: assert property (@(posedge sys_clk)
        disable iff (!reset_n) inVerify |=> !radioEnable)
        else $error("radio on in verification");
    chk_power_sub: assert property (@(posedge sys_clk)
        disable iff (!reset_n) flowFault |=> measSerial.power == POWER_SUB)
        else $error("power not zeroed");
    chk_dial_ship: assert property (@(posedge sys_clk)
        disable iff (!reset_n) (inShip && dialPress && !integrationPulse
        && !finishConfiguration && !verifyEnter) |=> inShip)
        else $error("dial left shipping");
    chk_menu_block: assert property (@(posedge sys_clk)
        disable iff (!reset_n) finishConfiguration |=> !menuAccess)
        else $error("menu open after finish");
endmodule
`default_nettype wire

// ### tb/fcs_front_model.sv
/*
 front key model: presses the primary or secondary key and holds both
 keys for a forced dial until the dial indicator shows or 20 cycles pass.
 assumes keys are active high pins that read low when released.
*/
`timescale 1ns/1ps
`default_nettype none
module fcs_front_model (
    input  wire logic sys_clk,
    input  wire logic dialShown,
    output var logic  primaryKey,
    output var logic  secondaryKey,
    output var logic  bothKeysHeld
);
    initial begin
        primaryKey = 1'b0;
        secondaryKey = 1'b0;
        bothKeysHeld = 1'b0;
    end

    // held long enough to pass the pin synchronisers
    task automatic press(input int k);
        @(posedge sys_clk);
        if (k == 0) primaryKey <= 1'b1;
        else secondaryKey <= 1'b1;
        repeat (4) @(posedge sys_clk);
        primaryKey <= 1'b0;
        secondaryKey <= 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // gives up after 20 cycles, as an operator would
    task automatic dial(output logic shown);
        int n;
        n = 0;
        shown = 1'b0;
        @(posedge sys_clk);
        bothKeysHeld <= 1'b1;
        while (!shown && n < 20) begin
            @(negedge sys_clk);
            n++;
            shown = (dialShown === 1'b1);
        end
        @(posedge sys_clk);
        bothKeysHeld <= 1'b0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
/*
 testbench for the fault code and shipping state controller.
 assumes the front key model drives the key pins; the bench drives the
 monitor pins, pulses and measurement words at the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
    import fcs_pkg::*;
;
    localparam int P_INT = 0;
    localparam int P_FIN = 1;
    localparam int P_MENU = 2;
    localparam int P_VIN = 3;
    localparam int P_VOUT = 4;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] monitorFaults = 16'h0000;
    logic [4:0] pulses = 5'h00;
    logic housingOpen = 1'b0;
    logic [23:0] dateNow = 24'h000000;
    fcs_meas_t measRaw = {16'h1234, 16'h0567, 24'h000abc, 24'h000def};
    logic primaryKey, secondaryKey, bothKeysHeld, faultFlash, viewIsDate;
    logic [15:0] fault_status_word, viewValue, eventCount, w;
    logic [23:0] viewDate;
    logic [1:0] measProfile;
    fcs_view_t viewMode;
    fcs_meas_t measSerial;
    logic dashInlet, dashOutlet, dashDiff, dashFlow, dashPower, s;
    logic holdHeatEnergy, holdCoolEnergy, shipping, powerSaveSeq;
    logic menuAccess, radioEnable;
    logic configMenuReq = 1'b1;
    logic [1:0] profileCode = 2'h2;
    logic [23:0] timeNow = 24'h123456;
    logic [31:0] heatEnergy = 32'h00001111;
    logic [31:0] coolEnergy = 32'h00002222;
    wire pInt = pulses[P_INT];
    wire pFin = pulses[P_FIN];
    wire pMenu = pulses[P_MENU];
    wire pVin = pulses[P_VIN];
    wire pVout = pulses[P_VOUT];
    int error_cnt = 0;
    int n_compared = 0;

    initial forever #50 sys_clk = ~sys_clk;

    fcs_front_model i_front (.sys_clk(sys_clk), .dialShown(radioEnable),
        .primaryKey(primaryKey), .secondaryKey(secondaryKey),
        .bothKeysHeld(bothKeysHeld));

    fault_code_and_shipping_state #(.LOG_DEPTH(FCS_LOG_DEPTH)) i_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .monitorFaults(monitorFaults),
        .primaryKey(primaryKey), .secondaryKey(secondaryKey),
        .bothKeysHeld(bothKeysHeld), .housingOpen(housingOpen),
        .integrationPulse(pInt), .finishConfiguration(pFin),
        .menuRadioEnable(pMenu), .verifyEnter(pVin),
        .verifyExit(pVout), .configMenuReq(configMenuReq),
        .profileCode(profileCode), .dateNow(dateNow), .timeNow(timeNow),
        .heatEnergy(heatEnergy), .coolEnergy(coolEnergy),
        .measRaw(measRaw), .fault_status_word(fault_status_word),
        .faultFlash(faultFlash), .viewMode(viewMode), .viewValue(viewValue),
        .viewDate(viewDate), .viewIsDate(viewIsDate),
        .eventCount(eventCount), .measSerial(measSerial),
        .dashInlet(dashInlet), .dashOutlet(dashOutlet), .dashDiff(dashDiff),
        .dashFlow(dashFlow), .dashPower(dashPower),
        .holdHeatEnergy(holdHeatEnergy), .holdCoolEnergy(holdCoolEnergy),
        .shipping(shipping), .powerSaveSeq(powerSaveSeq),
        .measProfile(measProfile), .menuAccess(menuAccess),
        .radioEnable(radioEnable));

    task automatic check(input string name, input logic [95:0] seen,
                         input logic [95:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic rst;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        monitorFaults <= 16'h0000;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(negedge sys_clk);
    endtask

    // pin answers land three edges after the change
    task automatic apply(input logic [15:0] f, input logic [23:0] d = 0);
        @(posedge sys_clk);
        monitorFaults <= f;
        dateNow <= d;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic pulse(input int b);
        @(posedge sys_clk);
        pulses[b] <= 1'b1;
        @(posedge sys_clk);
        pulses[b] <= 1'b0;
        @(negedge sys_clk);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(negedge sys_clk);
        check("shipping", shipping, 1);
        check("radio", radioEnable, 0);
        check("count", eventCount, 0);
        check("powersave", powerSaveSeq, 1);
        check("menu", menuAccess, 1);
        for (int i = 0; i < 16; i++) begin
            apply(16'h0001 << i);
            w = (i == 10) ? 16'h0000 : 16'h0001 << i;
            check("word", fault_status_word, w);
            check("flash", faultFlash, w != 0);
        end
        check("count", eventCount, 0);
        apply(16'h0020);
        check("inlet", measSerial.inletTemp, TEMP_SUB_LOW);
        check("power", measSerial.power, POWER_SUB);
        check("dash", {dashInlet, dashOutlet, dashDiff, dashPower, dashFlow},
              5'b10110);
        check("hold", holdHeatEnergy, 1);
        apply(16'h0010);
        check("outlet", measSerial.outletTemp, TEMP_SUB_HIGH);
        check("dash", dashOutlet, 1);
        apply(16'h0080);
        check("meas", measSerial, measRaw);
        check("dash", {dashInlet, dashOutlet, dashPower}, 0);
        apply(16'h0200);
        check("flow", measSerial.flow, FLOW_SUB);
        check("power", measSerial.power, POWER_SUB);
        check("dash", {dashFlow, dashPower}, 2'b11);
        check("hold", holdCoolEnergy, 1);
        apply(16'h0800);
        check("meas", measSerial, measRaw);
        check("noflow", {dashFlow, holdHeatEnergy}, 0);
        i_front.press(0);
        check("view", viewMode, FCS_VIEW_CODE);
        check("flash", faultFlash, 0);
        i_front.press(0);
        check("flash", faultFlash, 1);
        i_front.dial(s);
        check("dial", {s, radioEnable, shipping}, 3'b111);
        rst();
        pulse(P_MENU);
        check("menuradio", {radioEnable, shipping}, 2'b11);
        $display("test shipping state done");

        rst();
        pulse(P_INT);
        check("shipping", shipping, 0);
        check("radio", radioEnable, 1);
        check("profile", {measProfile, powerSaveSeq}, 3'b100);
        pulse(P_FIN);
        check("blocked", menuAccess, 0);
        @(posedge sys_clk);
        housingOpen <= 1'b1;
        apply(16'h0100);
        check("count", eventCount, 0);
        check("menu", menuAccess, 1);
        @(posedge sys_clk);
        housingOpen <= 1'b0;
        repeat (3) @(posedge sys_clk);
        for (int i = 1; i <= 52; i++) apply(16'(i), 24'(i));
        check("count", eventCount, 52);
        i_front.press(0);
        check("codeview", viewValue, 52);
        i_front.press(1);
        check("view", viewMode, FCS_VIEW_COUNT);
        check("counter", viewValue, 52);
        for (int k = 0; k < 50; k++) begin
            i_front.press(1);
            check("isdate", viewIsDate, 1);
            check("date", viewDate, 52 - k);
            i_front.press(1);
            check("isdate", viewIsDate, 0);
            check("code", viewValue, 52 - k);
        end
        $display("test logging done");

        rst();
        pulse(P_FIN);
        check("finish", {shipping, menuAccess}, 0);
        pulse(P_INT);
        check("radio", radioEnable, 1);
        pulse(P_VIN);
        check("radio", radioEnable, 0);
        pulse(P_INT);
        check("radio", radioEnable, 0);
        i_front.dial(s);
        check("dial", {s, radioEnable}, 0);
        pulse(P_VOUT);
        @(posedge sys_clk);
        housingOpen <= 1'b1;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        check("menu", menuAccess, 1);
        @(posedge sys_clk);
        configMenuReq <= 1'b0;
        profileCode <= 2'h1;
        @(negedge sys_clk);
        check("menureq", menuAccess, 0);
        check("profile", measProfile, 2'h1);
        $display("test commissioning done");
        print_verdict();
    end
endmodule
`default_nettype wire
